// ### bench/ioac_host_model.sv
`timescale 1ns/1ns
`include "ioac_cfg.svh"

module ioac_host_model
  import ioac_pkg::*;
(
  // clock
  input  wire logic        clk_sys,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdData;
  logic        rdErr;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'hff;
    pwdata  = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      tb_top.fail_count++;
      tb_top.stop_test();
    end
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines carry junk so a late sample cannot pass
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask

  // skew corrupts the checksum on purpose
  task automatic sendCmd(input logic [7:0] ins, typ, bank, input logic [31:0] val, input logic [7:0] skew);
    logic [7:0] s;
    s = 8'h01 + ins + typ + bank + val[31:24] + val[23:16] + val[15:8] + val[7:0] + skew;
    xfer(1'b1, `IOAC_REG_CMD_HDR, {8'h01, ins, typ, bank});
    xfer(1'b1, `IOAC_REG_CMD_VAL, val);
    xfer(1'b1, `IOAC_REG_CMD_CHK, {24'h0, s});
    repeat (2) @(posedge clk_sys);
  endtask
endmodule // ioac_host_model

// ### bench/ioac_top_asserts.sv
`timescale 1ns/1ns
`include "ioac_cfg.svh"

module ioac_top_asserts
  import ioac_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // outputs
  input wire logic        gpOutput0,
  input wire logic        gpOutput1,
  input wire logic        gpOutput2,
  input wire logic        gpOutput3
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  wire logic [3:0] outs  = {gpOutput3, gpOutput2, gpOutput1, gpOutput0};
  wire logic       chkWr = psel & penable & pready & pwrite & (paddr == `IOAC_REG_CMD_CHK);
  wire logic       outRd = psel & penable & pready & ~pwrite & (paddr == `IOAC_REG_OUT);

  AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  AST_UNMAPPED_ERR: assert property (psel && !penable && paddr > `IOAC_REG_OUT |=> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  AST_MAPPED_OK: assert property (psel && !penable && paddr <= `IOAC_REG_OUT && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped access refused");
  AST_OUT_BY_CMD: assert property (outs != $past(outs) |-> $past(chkWr, 2))
    else $error("outputs moved without a command");
  AST_OUT_READBACK: assert property (outRd |-> prdata[3:0] == outs)
    else $error("output register disagrees with pins");

  cover property (chkWr);
  cover property (pslverr);
  cover property (outs != $past(outs));
endmodule // ioac_top_asserts

bind ioac_top ioac_top_asserts u_ioac_top_asserts (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .gpOutput0, .gpOutput1, .gpOutput2, .gpOutput3);

// ### bench/tb_top.sv
`timescale 1ns/1ns
`include "ioac_cfg.svh"

module tb_top
  import ioac_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  gpIn = 4'h0;
  logic        moduleEnabled = 1'b1;
  logic [15:0] adc [4] = '{16'hffff, 16'h0000, 16'h8001, 16'h012e};
  logic [7:0]  opT [10] = '{8'h09, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
  logic [31:0] opnd [10] = '{32'h64, 32'h5, 32'hcd, 32'hfffffffd, 32'hfffffff9, 32'h5, 32'hff, 32'h100,
                             32'h3, 32'h0};
  logic [31:0] accT [10] = '{32'h64, 32'h69, 32'hffffff9c, 32'h12c, 32'hffffffd6, 32'hfffffffe, 32'hfe,
                             32'h1fe, 32'h1fd, 32'hfffffe02};
  logic [31:0] cAcc [4] = '{32'd1000, 32'd1000, 32'd1000, 32'hffffffff};
  logic [31:0] cOp [4] = '{32'd1000, 32'd999, 32'd1001, 32'h1};
  logic [7:0]  cMet [4] = '{8'ha5, 8'h3a, 8'hca, 8'hca};
  wire  logic        psel, penable, pwrite, pready, pslverr, condMet;
  wire  logic [7:0]  paddr;
  wire  logic [31:0] pwdata, prdata;
  wire  logic [3:0]  outs;
  int fail_count = 0;
  int check_count = 0;

  always #5 clk_sys = ~clk_sys;

  ioac_top u_ioac_top (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .gpInput0(gpIn[0]), .gpInput1(gpIn[1]), .gpInput2(gpIn[2]), .gpInput3(gpIn[3]),
    .adcResult0(adc[0]), .adcResult1(adc[1]), .adcResult2(adc[2]), .adcResult3(adc[3]), .moduleEnabled,
    .gpOutput0(outs[0]), .gpOutput1(outs[1]), .gpOutput2(outs[2]), .gpOutput3(outs[3]), .condMet);

  ioac_host_model u_ioac_host_model (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    u_ioac_host_model.xfer(1'b0, a, 32'h0);
    check(u_ioac_host_model.rdData, exp);
  endtask

  task automatic cmd(input logic [7:0] ins, typ, bank, input logic [31:0] val, input logic [7:0] st,
                     input logic [31:0] ev);
    u_ioac_host_model.sendCmd(ins, typ, bank, val, 8'h00);
    rd(`IOAC_REG_RPL_HDR, {8'h02, 8'h01, st, ins});
    if (st == `IOAC_ST_OK) begin
      rd(`IOAC_REG_RPL_VAL, ev);
    end
  endtask

  task automatic setOut(input logic [7:0] p, input logic [31:0] v, input logic [7:0] st);
    cmd(`IOAC_INS_SET_OUT, p, `IOAC_BANK_DOUT, v, st, v);
  endtask

  task automatic getIn(input logic [7:0] p, bank, input logic [31:0] ev);
    cmd(`IOAC_INS_GET_IN, p, bank, 32'h0, `IOAC_ST_OK, ev);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`IOAC_REG_CFG, `IOAC_CFG_RST);
    rd(`IOAC_REG_OUT, 32'h0);
    rd(8'h40, 32'h0);
    check({31'h0, u_ioac_host_model.rdErr}, 32'h1);
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      setOut(p[7:0], 32'h1, `IOAC_ST_OK);
      check({28'h0, outs}, (32'h2 << p) - 32'h1);
      getIn(p[7:0], `IOAC_BANK_DOUT, 32'h1);
    end
    setOut(8'h00, 32'h2, `IOAC_ST_BAD_VAL);
    check({28'h0, outs}, 32'hf);
    setOut(`IOAC_PORT_ALL, 32'h5, `IOAC_ST_OK);
    check({28'h0, outs}, 32'h5);
    getIn(8'h01, `IOAC_BANK_DOUT, 32'h0);
    cmd(`IOAC_INS_ARITH, `IOAC_OP_LOAD, 8'h00, 32'ha, `IOAC_ST_OK, 32'ha);
    setOut(`IOAC_PORT_ALL, `IOAC_VAL_USE_ACC, `IOAC_ST_OK);
    check({28'h0, outs}, 32'ha);
    cmd(`IOAC_INS_SET_OUT, 8'h00, 8'h00, 32'h1, `IOAC_ST_BAD_VAL, 32'h0);
    $display("test outputs done");
    @(posedge clk_sys);
    gpIn          <= 4'h6;
    moduleEnabled <= 1'b0;
    getIn(`IOAC_PORT_ALL, `IOAC_BANK_DIN, 32'h6);
    rd(`IOAC_REG_ACC, 32'h6);
    for (int p = 0; p < 4; p++) begin
      getIn(p[7:0], `IOAC_BANK_DIN, {31'h0, gpIn[p]});
      getIn(p[7:0], `IOAC_BANK_AIN, {16'h0, adc[p]});
    end
    getIn(`IOAC_PORT_ENABLE, `IOAC_BANK_DIN, 32'h1);
    rd(`IOAC_REG_ACC, 32'h6);
    cmd(`IOAC_INS_GET_IN, 8'h04, `IOAC_BANK_DIN, 32'h0, `IOAC_ST_BAD_TYPE, 32'h0);
    @(posedge clk_sys);
    moduleEnabled <= 1'b1;
    getIn(`IOAC_PORT_ENABLE, `IOAC_BANK_DIN, 32'h0);
    u_ioac_host_model.xfer(1'b1, `IOAC_REG_CFG, `IOAC_CFG_RST | 32'h1);
    getIn(8'h03, `IOAC_BANK_AIN, 32'h12e);
    rd(`IOAC_REG_ACC, 32'h12e);
    $display("test inputs done");
    for (int i = 0; i < 10; i++) begin
      cmd(`IOAC_INS_ARITH, opT[i], 8'h00, opnd[i], `IOAC_ST_OK, opnd[i]);
      rd(`IOAC_REG_ACC, accT[i]);
    end
    cmd(`IOAC_INS_ARITH, `IOAC_OP_DIV, 8'h00, 32'h0, `IOAC_ST_BAD_VAL, 32'h0);
    cmd(`IOAC_INS_ARITH, 8'h0a, 8'h00, 32'h5, `IOAC_ST_BAD_TYPE, 32'h0);
    rd(`IOAC_REG_ACC, 32'hfffffe02);
    // compare is issued only with standalone mode set
    for (int i = 0; i < 4; i++) begin
      cmd(`IOAC_INS_ARITH, `IOAC_OP_LOAD, 8'h00, cAcc[i], `IOAC_ST_OK, cAcc[i]);
      cmd(`IOAC_INS_COMPARE, 8'h00, 8'h00, cOp[i], `IOAC_ST_OK, cOp[i]);
      for (int c = 0; c < 8; c++) begin
        u_ioac_host_model.xfer(1'b1, `IOAC_REG_CFG, `IOAC_CFG_RST | 32'h1 | 32'(c << 4));
        repeat (3) @(posedge clk_sys);
        check({31'h0, condMet}, {31'h0, cMet[i][c]});
      end
    end
    rd(`IOAC_REG_RPL_CHK, 32'h7c);
    rd(`IOAC_REG_STAT, 32'h112);
    u_ioac_host_model.xfer(1'b1, `IOAC_REG_STAT, 32'h2);
    rd(`IOAC_REG_STAT, 32'h110);
    u_ioac_host_model.sendCmd(`IOAC_INS_SET_OUT, `IOAC_PORT_ALL, `IOAC_BANK_DOUT, 32'h0, 8'h01);
    rd(`IOAC_REG_RPL_HDR, {8'h02, 8'h01, `IOAC_ST_BAD_CHK, `IOAC_INS_SET_OUT});
    check({28'h0, outs}, 32'ha);
    $display("test arithmetic done");
    stop_test();
  end
endmodule // tb_top

// ### src/ioac_alu.sv
`timescale 1ns/1ns

module ioac_alu
  import ioac_pkg::*;
(
  // operands and result
  ioac_link_if.alu lnk
);

  logic signed [63:0] prod;

  assign prod = lnk.acc * lnk.operand;

  always_comb begin
    lnk.divZero = 1'b0;
    case (lnk.op)
      `IOAC_OP_ADD:  lnk.result = lnk.acc + lnk.operand;
      `IOAC_OP_SUB:  lnk.result = lnk.acc - lnk.operand;
      // keep the low word, like a 32-bit processor would
      `IOAC_OP_MUL:  lnk.result = prod[31:0];
      `IOAC_OP_DIV,
      `IOAC_OP_MOD: begin
        if (lnk.operand == 32'sh0000_0000) begin
          lnk.divZero = 1'b1;
          lnk.result  = lnk.acc;
        end else if (lnk.op == `IOAC_OP_DIV) begin
          lnk.result = lnk.acc / lnk.operand;
        end else begin
          lnk.result = lnk.acc % lnk.operand;
        end
      end
      `IOAC_OP_AND:  lnk.result = lnk.acc & lnk.operand;
      `IOAC_OP_OR:   lnk.result = lnk.acc | lnk.operand;
      `IOAC_OP_XOR:  lnk.result = lnk.acc ^ lnk.operand;
      `IOAC_OP_NOT:  lnk.result = ~lnk.acc;
      `IOAC_OP_LOAD: lnk.result = lnk.operand;
      default:       lnk.result = lnk.acc;
    endcase
  end

endmodule // ioac_alu

// ### src/ioac_cfg.svh
`ifndef IOAC_CFG_SVH
`define IOAC_CFG_SVH

// apb register byte offsets
`define IOAC_ADDR_W        8
`define IOAC_REG_CMD_HDR   8'h00
`define IOAC_REG_CMD_VAL   8'h04
`define IOAC_REG_CMD_CHK   8'h08
`define IOAC_REG_RPL_HDR   8'h0c
`define IOAC_REG_RPL_VAL   8'h10
`define IOAC_REG_RPL_CHK   8'h14
`define IOAC_REG_CFG       8'h18
`define IOAC_REG_STAT      8'h1c
`define IOAC_REG_ACC       8'h20
`define IOAC_REG_OUT       8'h24

// config register fields
`define IOAC_CFG_STANDALONE 0
`define IOAC_CFG_COND_LSB   4
`define IOAC_CFG_COND_MSB   6
`define IOAC_CFG_HOST_LSB   8
`define IOAC_CFG_HOST_MSB   15
`define IOAC_CFG_MOD_LSB    16
`define IOAC_CFG_MOD_MSB    23
`define IOAC_CFG_RST        32'h0001_0200
`define IOAC_CFG_MASK       32'h00ff_ff71

// status register fields
`define IOAC_STAT_BUSY     0
`define IOAC_STAT_DONE     1
`define IOAC_STAT_FL_LSB   4
`define IOAC_STAT_FL_MSB   7
`define IOAC_STAT_COND     8

// instruction codes
`define IOAC_INS_SET_OUT   8'h0e
`define IOAC_INS_GET_IN    8'h0f
`define IOAC_INS_ARITH     8'h13
`define IOAC_INS_COMPARE   8'h14

// banks and ports
`define IOAC_BANK_DIN      8'h00
`define IOAC_BANK_AIN      8'h01
`define IOAC_BANK_DOUT     8'h02
`define IOAC_PORT_LAST     8'h03
`define IOAC_PORT_ALL      8'hff
`define IOAC_PORT_ENABLE   8'h0a
`define IOAC_VAL_USE_ACC   32'hffff_ffff

// arithmetic operations
`define IOAC_OP_ADD        8'h00
`define IOAC_OP_SUB        8'h01
`define IOAC_OP_MUL        8'h02
`define IOAC_OP_DIV        8'h03
`define IOAC_OP_MOD        8'h04
`define IOAC_OP_AND        8'h05
`define IOAC_OP_OR         8'h06
`define IOAC_OP_XOR        8'h07
`define IOAC_OP_NOT        8'h08
`define IOAC_OP_LOAD       8'h09

// reply status codes
`define IOAC_ST_OK         8'h64
`define IOAC_ST_BAD_CHK    8'h01
`define IOAC_ST_BAD_CMD    8'h02
`define IOAC_ST_BAD_TYPE   8'h03
`define IOAC_ST_BAD_VAL    8'h04

// branch conditions
`define IOAC_CC_ZE         3'h0
`define IOAC_CC_NZ         3'h1
`define IOAC_CC_EQ         3'h2
`define IOAC_CC_NE         3'h3
`define IOAC_CC_GT         3'h4
`define IOAC_CC_GE         3'h5
`define IOAC_CC_LT         3'h6
`define IOAC_CC_LE         3'h7

`endif

// ### src/ioac_in_sel.sv
`timescale 1ns/1ns

module ioac_in_sel
  import ioac_pkg::*;
(
  // port and bank selection
  ioac_link_if.sel lnk
);

  logic       onePort;
  logic [1:0] idx;

  assign onePort = lnk.port <= `IOAC_PORT_LAST;
  assign idx     = lnk.port[1:0];

  always_comb begin
    lnk.readVal = 32'h0000_0000;
    lnk.readOk  = 1'b0;
    case (lnk.bank)
      `IOAC_BANK_DIN: begin
        if (onePort) begin
          lnk.readVal = {31'h0000_0000, lnk.gpIn[idx]};
          lnk.readOk  = 1'b1;
        end else if (lnk.port == `IOAC_PORT_ALL) begin
          lnk.readVal = {28'h000_0000, lnk.gpIn};
          lnk.readOk  = 1'b1;
        end else if (lnk.port == `IOAC_PORT_ENABLE) begin
          // reads 0 while enabled
          lnk.readVal = {31'h0000_0000, ~lnk.modEnabled};
          lnk.readOk  = 1'b1;
        end
      end
      `IOAC_BANK_AIN: begin
        if (onePort) begin
          lnk.readVal = {16'h0000, lnk.adc[idx]};
          lnk.readOk  = 1'b1;
        end
      end
      `IOAC_BANK_DOUT: begin
        if (onePort) begin
          lnk.readVal = {31'h0000_0000, lnk.outLvl[idx]};
          lnk.readOk  = 1'b1;
        end
      end
      default: begin
        lnk.readVal = 32'h0000_0000;
        lnk.readOk  = 1'b0;
      end
    endcase
  end

endmodule // ioac_in_sel

// ### src/ioac_link_if.sv
`timescale 1ns/1ns

interface ioac_link_if;
  logic        [7:0]       op;
  logic signed [31:0]      acc;
  logic signed [31:0]      operand;
  logic signed [31:0]      result;
  logic                    divZero;
  logic        [7:0]       port;
  logic        [7:0]       bank;
  logic        [3:0]       outLvl;
  logic        [3:0]       gpIn;
  logic                    modEnabled;
  logic        [3:0][15:0] adc;
  logic        [31:0]      readVal;
  logic                    readOk;

  modport alu  (input op, acc, operand, output result, divZero);
  modport sel  (input port, bank, outLvl, gpIn, modEnabled, adc, output readVal, readOk);
  modport core (output op, acc, operand, port, bank, outLvl, gpIn, modEnabled, adc,
                input result, divZero, readVal, readOk);
endinterface

// ### src/ioac_pkg.sv
`include "ioac_cfg.svh"

package ioac_pkg;

  typedef enum logic [0:0] {IOAC_IDLE, IOAC_EXEC} ioac_state_t;

  typedef struct packed {
    logic zero;
    logic eq;
    logic gt;
    logic lt;
  } ioac_flags_t;

  // frame checksum: modulo-256 sum of eight bytes
  function automatic logic [7:0] ioacSum8(input logic [63:0] bytes);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = s + bytes[i*8 +: 8];
    end
    return s;
  endfunction

  function automatic logic ioacCondMet(input ioac_flags_t f, input logic [2:0] cc);
    logic r;
    r = 1'b0;
    case (cc)
      `IOAC_CC_ZE: r = f.zero;
      `IOAC_CC_NZ: r = ~f.zero;
      `IOAC_CC_EQ: r = f.eq;
      `IOAC_CC_NE: r = ~f.eq;
      `IOAC_CC_GT: r = f.gt;
      `IOAC_CC_GE: r = f.gt | f.eq;
      `IOAC_CC_LT: r = f.lt;
      `IOAC_CC_LE: r = f.lt | f.eq;
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

endpackage

// ### src/ioac_top.sv
// Function
// - code 14 sets outputs by port, bank
// - bank 2 ports 0-3 take 0 or 1
// - port 255 writes all outputs as vector
// - value -1 takes vector from accumulator
// - code 15 reads port in bank 0-2
// - digital reads 0/1, analog 0..65535
// - standalone copies to accumulator, direct not (the code also copies the port 255 bank 0 read in direct mode)
// - bank 0 gives digital input levels
// - port 255 bank 0 loads input vector
// - bank 1 gives analog conversion results
// - bank 2 gives last set output level
// - port 10 bank 0 reports enable, inverted
// - code 19 applies op type to accumulator
// - invert ignores operand; load takes operand
// - code 20 compares, updates status flags
// - flags serve eight branch conditions
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns

module ioac_top
  import ioac_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`IOAC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // general purpose inputs, converter results and module enable
  input  wire logic                     gpInput0,
  input  wire logic                     gpInput1,
  input  wire logic                     gpInput2,
  input  wire logic                     gpInput3,
  input  wire logic [15:0]              adcResult0,
  input  wire logic [15:0]              adcResult1,
  input  wire logic [15:0]              adcResult2,
  input  wire logic [15:0]              adcResult3,
  input  wire logic                     moduleEnabled,
  // general purpose outputs and the condition output
  output logic                          gpOutput0,
  output logic                          gpOutput1,
  output logic                          gpOutput2,
  output logic                          gpOutput3,
  output logic                          condMet
);

  ioac_link_if lnk ();

  ioac_alu u_alu (
    .lnk (lnk.alu)
  );

  ioac_in_sel u_sel (
    .lnk (lnk.sel)
  );

  // ---------------- state ----------------
  ioac_state_t        state_q;
  logic        [31:0] cmdHdr_q;
  logic        [31:0] cmdVal_q;
  logic        [7:0]  cmdChk_q;
  logic        [31:0] rplHdr_q;
  logic        [31:0] rplVal_q;
  logic        [7:0]  rplChk_q;
  logic        [31:0] cfg_q;
  logic signed [31:0] acc_q;
  ioac_flags_t        flags_q;
  logic        [3:0]  outLvl_q;
  logic               done_q;
  logic               condMet_q;
  logic        [31:0] prdata_q;
  logic               pready_q;
  logic               pslverr_q;

  // ---------------- apb decode ----------------
  logic        setupPh;
  logic        wrEn;
  logic        isMapped;
  logic [31:0] rdData;
  logic [31:0] statWord;
  logic        hitHdr;
  logic        hitVal;
  logic        hitChk;
  logic        hitCfg;
  logic        hitStat;
  logic        launch;

  assign setupPh = psel & ~penable;
  // the write lands only at the edge where the master sees pready
  assign wrEn    = psel & penable & pready_q & pwrite;
  assign hitHdr  = paddr == `IOAC_REG_CMD_HDR;
  assign hitVal  = paddr == `IOAC_REG_CMD_VAL;
  assign hitChk  = paddr == `IOAC_REG_CMD_CHK;
  assign hitCfg  = paddr == `IOAC_REG_CFG;
  assign hitStat = paddr == `IOAC_REG_STAT;
  assign launch  = wrEn & hitChk & (state_q == IOAC_IDLE);

  assign statWord = {23'h00_0000, condMet_q, flags_q, 2'b00, done_q, state_q == IOAC_EXEC};

  assign isMapped = hitHdr | hitVal | hitChk | hitCfg | hitStat |
                    (paddr == `IOAC_REG_RPL_HDR) | (paddr == `IOAC_REG_RPL_VAL) |
                    (paddr == `IOAC_REG_RPL_CHK) | (paddr == `IOAC_REG_ACC) |
                    (paddr == `IOAC_REG_OUT);

  assign rdData = hitHdr                         ? cmdHdr_q :
                  hitVal                         ? cmdVal_q :
                  hitChk                         ? {24'h00_0000, cmdChk_q} :
                  (paddr == `IOAC_REG_RPL_HDR)   ? rplHdr_q :
                  (paddr == `IOAC_REG_RPL_VAL)   ? rplVal_q :
                  (paddr == `IOAC_REG_RPL_CHK)   ? {24'h00_0000, rplChk_q} :
                  hitCfg                         ? cfg_q :
                  hitStat                        ? statWord :
                  (paddr == `IOAC_REG_ACC)       ? acc_q :
                  (paddr == `IOAC_REG_OUT)       ? {28'h000_0000, outLvl_q} :
                                                   32'h0000_0000;

  // ---------------- command fields ----------------
  logic        [7:0]  fTarget;
  logic        [7:0]  fIns;
  logic        [7:0]  fType;
  logic        [7:0]  fBank;
  logic signed [31:0] fValue;
  logic               standalone;
  logic        [7:0]  hostAddr;
  logic        [7:0]  modAddr;

  // target, instruction, type, bank, value msb first, checksum
  assign fTarget    = cmdHdr_q[31:24];
  assign fIns       = cmdHdr_q[23:16];
  assign fType      = cmdHdr_q[15:8];
  assign fBank      = cmdHdr_q[7:0];
  assign fValue     = cmdVal_q;
  assign standalone = cfg_q[`IOAC_CFG_STANDALONE];
  assign hostAddr   = cfg_q[`IOAC_CFG_HOST_MSB:`IOAC_CFG_HOST_LSB];
  assign modAddr    = cfg_q[`IOAC_CFG_MOD_MSB:`IOAC_CFG_MOD_LSB];

  logic chkOk;
  logic addrOk;
  logic isSet;
  logic isGet;
  logic isArith;
  logic isComp;

  assign chkOk   = ioacSum8({cmdHdr_q, cmdVal_q}) == cmdChk_q;
  assign addrOk  = fTarget == modAddr;
  assign isSet   = fIns == `IOAC_INS_SET_OUT;
  assign isGet   = fIns == `IOAC_INS_GET_IN;
  assign isArith = fIns == `IOAC_INS_ARITH;
  assign isComp  = fIns == `IOAC_INS_COMPARE;

  // ---------------- set output ----------------
  logic       setBankOk;
  logic       setOne;
  logic       setAll;
  logic       setValOk;
  logic [3:0] oneHot;
  logic [3:0] outOne;
  logic [3:0] outAll;
  logic [7:0] setStatus;
  logic       outWe;
  logic [3:0] outNew;

  assign setBankOk = fBank == `IOAC_BANK_DOUT;
  assign setOne    = fType <= `IOAC_PORT_LAST;
  assign setAll    = fType == `IOAC_PORT_ALL;
  assign setValOk  = (fValue == 32'sh0000_0000) | (fValue == 32'sh0000_0001);
  assign oneHot    = 4'h1 << fType[1:0];
  assign outOne    = fValue[0] ? (outLvl_q | oneHot) : (outLvl_q & ~oneHot);
  assign outAll    = (cmdVal_q == `IOAC_VAL_USE_ACC) ? acc_q[3:0] : cmdVal_q[3:0];
  assign setStatus = !setBankOk          ? `IOAC_ST_BAD_VAL :
                     setAll              ? `IOAC_ST_OK :
                     !setOne             ? `IOAC_ST_BAD_TYPE :
                     !setValOk           ? `IOAC_ST_BAD_VAL :
                                           `IOAC_ST_OK;
  assign outWe     = isSet & (setStatus == `IOAC_ST_OK);
  assign outNew    = setAll ? outAll : outOne;

  // ---------------- get input ----------------
  logic [7:0] getStatus;
  logic       getAccWe;
  logic       getAllIn;

  assign lnk.port       = fType;
  assign lnk.bank       = fBank;
  assign lnk.outLvl     = outLvl_q;
  assign lnk.gpIn       = {gpInput3, gpInput2, gpInput1, gpInput0};
  assign lnk.modEnabled = moduleEnabled;
  assign lnk.adc        = {adcResult3, adcResult2, adcResult1, adcResult0};
  assign getAllIn       = (fBank == `IOAC_BANK_DIN) & (fType == `IOAC_PORT_ALL);
  assign getStatus      = lnk.readOk ? `IOAC_ST_OK : `IOAC_ST_BAD_TYPE;
  // the all-inputs read always lands in the accumulator
  assign getAccWe       = isGet & lnk.readOk & (standalone | getAllIn);

  // ---------------- arithmetic and compare ----------------
  logic [7:0]  arithStatus;
  logic        arithAccWe;
  ioac_flags_t cmpFlags;

  assign lnk.op      = fType;
  assign lnk.acc     = acc_q;
  assign lnk.operand = fValue;
  assign arithStatus = (fType > `IOAC_OP_LOAD) ? `IOAC_ST_BAD_TYPE :
                       lnk.divZero             ? `IOAC_ST_BAD_VAL :
                                                 `IOAC_ST_OK;
  // a zero divisor leaves the accumulator untouched
  assign arithAccWe  = isArith & (arithStatus == `IOAC_ST_OK);

  assign cmpFlags.zero = (acc_q - fValue) == 32'sh0000_0000;
  assign cmpFlags.eq   = acc_q == fValue;
  assign cmpFlags.gt   = acc_q > fValue;
  assign cmpFlags.lt   = acc_q < fValue;

  // ---------------- result selection ----------------
  logic        [7:0]  exStatus;
  logic        [31:0] exValue;
  logic               accWe;
  logic signed [31:0] accNew;
  logic        [31:0] rplHdrNew;
  logic               exGo;

  assign exGo     = (state_q == IOAC_EXEC) & addrOk;
  assign exStatus = !chkOk  ? `IOAC_ST_BAD_CHK :
                    isSet   ? setStatus :
                    isGet   ? getStatus :
                    isArith ? arithStatus :
                    isComp  ? `IOAC_ST_OK :
                              `IOAC_ST_BAD_CMD;
  assign exValue  = (isGet & chkOk) ? lnk.readVal : cmdVal_q;
  assign accWe    = exGo & chkOk & (getAccWe | arithAccWe);
  assign accNew   = isGet ? $signed(lnk.readVal) : lnk.result;
  // host, target, status, instruction, value msb first, checksum
  assign rplHdrNew = {hostAddr, modAddr, exStatus, fIns};

  // ---------------- registers ----------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= IOAC_IDLE;
    end else begin
      case (state_q)
        IOAC_IDLE: state_q <= launch ? IOAC_EXEC : IOAC_IDLE;
        IOAC_EXEC: state_q <= IOAC_IDLE;
        default:   state_q <= IOAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmdHdr_q <= 32'h0000_0000;
      cmdVal_q <= 32'h0000_0000;
      cmdChk_q <= 8'h00;
      cfg_q    <= `IOAC_CFG_RST;
    end else begin
      // frame fields are frozen while a command executes
      if (wrEn & hitHdr & (state_q == IOAC_IDLE)) cmdHdr_q <= pwdata;
      if (wrEn & hitVal & (state_q == IOAC_IDLE)) cmdVal_q <= pwdata;
      if (launch) cmdChk_q <= pwdata[7:0];
      if (wrEn & hitCfg) cfg_q <= pwdata & `IOAC_CFG_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rplHdr_q <= 32'h0000_0000;
      rplVal_q <= 32'h0000_0000;
      rplChk_q <= 8'h00;
    end else if (exGo) begin
      rplHdr_q <= rplHdrNew;
      rplVal_q <= exValue;
      rplChk_q <= ioacSum8({rplHdrNew, exValue});
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_q    <= 32'sh0000_0000;
      outLvl_q <= 4'h0;
      flags_q  <= '0;
    end else begin
      if (accWe) acc_q <= accNew;
      if (exGo & chkOk & outWe) outLvl_q <= outNew;
      if (exGo & chkOk & isComp) flags_q <= cmpFlags;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      done_q    <= 1'b0;
      condMet_q <= 1'b0;
    end else begin
      // a fresh reply wins over a software clear in the same cycle
      if (exGo) begin
        done_q <= 1'b1;
      end else if (wrEn & hitStat & pwdata[`IOAC_STAT_DONE]) begin
        done_q <= 1'b0;
      end
      condMet_q <= ioacCondMet(flags_q, cfg_q[`IOAC_CFG_COND_MSB:`IOAC_CFG_COND_LSB]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      // zero wait states: data captured in setup, ready in access
      pready_q  <= setupPh;
      prdata_q  <= (setupPh & ~pwrite) ? rdData : 32'h0000_0000;
      pslverr_q <= setupPh & ~isMapped;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign gpOutput0 = outLvl_q[0];
  assign gpOutput1 = outLvl_q[1];
  assign gpOutput2 = outLvl_q[2];
  assign gpOutput3 = outLvl_q[3];
  assign condMet   = condMet_q;

endmodule // ioac_top
